// ==== shared/pwm_stage_pkg.sv ====
// Constants for the PWM output stage configuration block.
// Assumes a 32-bit AXI4-Lite master and an 8-bit register space.
package pwm_stage_pkg;
    localparam int          ADDR_W      = 8;
    localparam int          NCH         = 8;
    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_CTRL    = 8'h02;
    localparam logic [7:0]  IDX_CFG     = 8'h31;
    localparam logic [7:0]  IDX_MINP    = 8'h32;
    localparam logic [7:0]  IDX_DLY     = 8'h33;
    localparam logic [7:0]  IDX_PSR     = 8'h34;
    localparam logic [7:0]  ADR_CTRL    = 8'(IDX_CTRL * 4);
    localparam logic [7:0]  ADR_CFG     = 8'(IDX_CFG * 4);
    localparam logic [7:0]  ADR_MINP    = 8'(IDX_MINP * 4);
    localparam logic [7:0]  ADR_DLY     = 8'(IDX_DLY * 4);
    localparam logic [7:0]  ADR_PSR     = 8'(IDX_PSR * 4);
    // Field positions
    localparam int          CTRL_PDN    = 0;
    localparam int          CTRL_SYNC   = 7;
    localparam int          CFG_P1      = 4;
    localparam int          CFG_P2      = 3;
    localparam int          CFG_A3      = 2;
    localparam int          CFG_B3      = 1;
    localparam int          CFG_P4      = 0;
    localparam int          MINP_DIS    = 7;
    localparam int          MINP_LSB    = 0;
    localparam int          DLY_LEG_LSB = 5;
    localparam int          DLY_PR_LSB  = 0;
    localparam int          SUPPLY_REJECT_ENABLE      = 7;
    localparam int          PSR_RST     = 6;
    localparam int          PSR_FB      = 5;
    localparam int          PSR_DIV_LSB = 0;
    // Writable-bit masks and reset values
    localparam logic [7:0]  MASK_CTRL   = 8'h01;
    localparam logic [7:0]  MASK_CFG    = 8'h1F;
    localparam logic [7:0]  MASK_MINP   = 8'h9F;
    localparam logic [7:0]  MASK_DLY    = 8'hFF;
    localparam logic [7:0]  MASK_PSR    = 8'hE7;
    localparam logic [7:0]  RST_CTRL    = 8'h01;
    localparam logic [7:0]  RST_ZERO    = 8'h00;
    // Delay line and divider sizing, bus response codes
    localparam int          TAPS        = 38;
    localparam logic [2:0]  DIV_OFF     = 3'h0;
    localparam logic [2:0]  DIV_LAST    = 3'h6;
    localparam logic [2:0]  DIV_SHIFT   = 3'h3;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// ==== hdl/supply_sync_gen.sv ====
// Supply sync clock divider from the crystal clock.
// Assumes aclk is the crystal clock.
`timescale 1ns/100ps
module supply_sync_gen
    import pwm_stage_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Control and output
    input  wire logic [2:0] div_code,
    output logic            sync_clk
);
    typedef struct packed {
        logic [9:0] cnt;
        logic       clk;
    } sync_state_type;

    sync_state_type s_reg;
    sync_state_type s_next;
    logic [9:0]     half_last;

    always_comb begin
        s_next    = s_reg;
        // Shift amount widened so codes five and six do not wrap
        half_last = 10'((11'h1 << (4'(div_code) + 4'(DIV_SHIFT))) - 11'h1);
        if (div_code == DIV_OFF || div_code > DIV_LAST) begin
            s_next = '0;
        end else if (s_reg.cnt >= half_last) begin
            s_next.cnt = '0;
            s_next.clk = ~s_reg.clk;
        end else begin
            s_next.cnt = s_reg.cnt + 10'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sync_clk = s_reg.clk;

    a_sync_off: assert property (@(posedge aclk) disable iff (!aresetn)
        (div_code == DIV_OFF)[*2] |-> !sync_clk) else $error("sync clock runs while off");
    a_sync_div32: assert property (@(posedge aclk) disable iff (!aresetn)
        ($rose(sync_clk) && div_code == 3'h1) |-> ##[1:16] (!sync_clk || div_code != 3'h1))
        else $error("divide by 32 half period too long");
endmodule

// ==== hdl/pwm_leg_shaper.sv ====
// Minimum pulse and delay shaping of one channel's plus and minus legs.
// Assumes mclk_en is a one-cycle PWM master clock tick on aclk.
`timescale 1ns/100ps
module pwm_leg_shaper
    import pwm_stage_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       mclk_en,
    // Settings
    input  wire logic [4:0] min_pulse,
    input  wire logic [2:0] leg_delay,
    input  wire logic [4:0] pair_delay,
    input  wire logic       full_bridge,
    input  wire logic       minus_disable,
    // Legs, index 0 plus and 1 minus
    input  wire logic [1:0] raw,
    output logic [1:0]      leg_out
);
    typedef struct packed {
        logic [1:0][4:0]      held;
        logic [1:0]           lvl;
        logic [1:0][TAPS-1:0] line;
        logic [1:0]           out;
    } leg_state_type;

    leg_state_type s_reg;
    leg_state_type s_next;
    logic [1:0][5:0] dly;
    logic [1:0]      tap;

    always_comb begin
        s_next = s_reg;
        dly[0] = {1'b0, pair_delay};
        dly[1] = 6'({1'b0, pair_delay} + {3'h0, leg_delay});
        for (int l = 0; l < 2; l++) begin
            tap[l] = (dly[l] == 6'h0) ? s_reg.lvl[l] : s_reg.line[l][6'(dly[l] - 6'h1)];
            if (mclk_en) begin
                if (s_reg.held[l] != 5'h1F) begin
                    s_next.held[l] = s_reg.held[l] + 5'h1;
                end
                if (raw[l] != s_reg.lvl[l] && s_reg.held[l] >= min_pulse) begin
                    s_next.lvl[l]  = raw[l];
                    // Count from one so a pulse of exactly the setting passes
                    s_next.held[l] = 5'h1;
                end
                s_next.line[l] = {s_reg.line[l][TAPS-2:0], s_reg.lvl[l]};
            end
        end
        s_next.out[0] = tap[0];
        s_next.out[1] = tap[1] & ~(minus_disable & ~full_bridge);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign leg_out = s_reg.out;

    a_minus_off: assert property (@(posedge aclk) disable iff (!aresetn)
        (minus_disable && !full_bridge) |=> !leg_out[1]) else $error("minus leg not off");
    a_full_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
        (full_bridge && tap[1]) |=> leg_out[1]) else $error("full bridge minus dropped");
    a_min_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(s_reg.lvl[0]) |-> $past(s_reg.held[0]) >= $past(min_pulse))
        else $error("pulse shorter than minimum");
    a_no_delay: assert property (@(posedge aclk) disable iff (!aresetn)
        (pair_delay == 5'h0 && leg_delay == 3'h0) |=> leg_out[0] == $past(s_reg.lvl[0]))
        else $error("zero delay not transparent");
endmodule

// ==== hdl/pwm_output_stage_config.sv ====
// Output stage configuration for an eight-channel PWM modulator.
// Assumes an AXI4-Lite master and modulator legs on aclk.
//
// Overview of operation
// - Pair two bit selects half or full
// - Channel A3 bit selects half or full
// - Channel B3 bit selects half or full
// - Pair four bit selects half or full
// - Stage settings writable only while powered down
// - Minus disable mutes half-bridge minus legs
// - Full-bridge channels ignore minus disable
// - One minimum pulse setting for all legs
// - Minimum pulse is setting times master periods
// - Minus leg delayed by leg delay count
// - A pair delayed from B by pair count
// - Leg delay is zero after reset
// - Supply rejection enable bit drives its output
// - Supply rejection reset low while bit zero
// - Divider code sets supply sync clock rate
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
module pwm_output_stage_config
    import pwm_stage_pkg::*;
(
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write address
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    // AXI4-Lite write data
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    // AXI4-Lite write response
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic [1:0]             s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    // AXI4-Lite read data
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    // Modulator legs and master clock tick
    input  wire logic              mclk_en,
    input  wire logic [NCH-1:0]    mod_plus,
    input  wire logic [NCH-1:0]    mod_minus,
    // Power stage outputs
    output logic [NCH-1:0]         pwm_plus_out,
    output logic [NCH-1:0]         pwm_minus_out,
    // Supply rejection outputs
    output logic                   supply_reject_enable,
    output logic                   supply_reject_reset_n,
    output logic                   feedback_enable,
    output logic                   supply_sync_clock
);
    typedef struct packed {
        logic                aw_hold;
        logic                w_hold;
        logic [ADDR_W-1:0]   aw_addr;
        logic [7:0]          w_data;
        logic                w_lane;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                rvalid;
        logic [1:0]          rresp;
        logic [7:0]          rdata;
        logic [7:0]          ctrl;
        logic [7:0]          cfg;
        logic [7:0]          minp;
        logic [7:0]          dly;
        logic [7:0]          psr;
    } cfg_state_type;

    cfg_state_type  s_reg;
    cfg_state_type  s_next;
    logic           wr_fire;
    logic           power_down_bit;
    logic [NCH-1:0] full_bridge;
    logic [7:0]     ctrl_view;

    assign wr_fire = s_reg.aw_hold && s_reg.w_hold && !s_reg.bvalid;
    assign power_down_bit     = s_reg.ctrl[CTRL_PDN];

    // Channel order A1 B1 A2 B2 A3 B3 A4 B4
    assign full_bridge = {
        s_reg.cfg[CFG_P4], s_reg.cfg[CFG_P4],
        s_reg.cfg[CFG_B3],
        s_reg.cfg[CFG_A3],
        s_reg.cfg[CFG_P2], s_reg.cfg[CFG_P2],
        s_reg.cfg[CFG_P1], s_reg.cfg[CFG_P1]
    };

    always_comb begin
        ctrl_view            = s_reg.ctrl & MASK_CTRL;
        ctrl_view[CTRL_SYNC] = supply_sync_clock;
    end

    always_comb begin
        s_next = s_reg;

        // Address and data are taken independently, in either order
        if (s_axi_awvalid && !s_reg.aw_hold) begin
            s_next.aw_hold = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_reg.w_hold) begin
            s_next.w_hold = 1'b1;
            s_next.w_data = s_axi_wdata[7:0];
            s_next.w_lane = s_axi_wstrb[0];
        end

        if (wr_fire) begin
            s_next.aw_hold = 1'b0;
            s_next.w_hold  = 1'b0;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = RESP_OKAY;
            unique case (s_reg.aw_addr)
                ADR_CTRL: begin
                    if (s_reg.w_lane) begin
                        s_next.ctrl = s_reg.w_data & MASK_CTRL;
                    end
                end
                // Locked while running: a refused write still answers OKAY
                ADR_CFG: begin
                    if (s_reg.w_lane && power_down_bit) begin
                        s_next.cfg = s_reg.w_data & MASK_CFG;
                    end
                end
                ADR_MINP: begin
                    if (s_reg.w_lane && power_down_bit) begin
                        s_next.minp = s_reg.w_data & MASK_MINP;
                    end
                end
                ADR_DLY: begin
                    if (s_reg.w_lane && power_down_bit) begin
                        s_next.dly = s_reg.w_data & MASK_DLY;
                    end
                end
                ADR_PSR: begin
                    if (s_reg.w_lane) begin
                        s_next.psr = s_reg.w_data & MASK_PSR;
                    end
                end
                default: begin
                    s_next.bresp = RESP_SLVERR;
                end
            endcase
        end else if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end

        if (s_axi_arvalid && !s_reg.rvalid) begin
            s_next.rvalid = 1'b1;
            s_next.rresp  = RESP_OKAY;
            unique case (s_axi_araddr)
                ADR_CTRL: s_next.rdata = ctrl_view;
                ADR_CFG:  s_next.rdata = s_reg.cfg;
                ADR_MINP: s_next.rdata = s_reg.minp;
                ADR_DLY:  s_next.rdata = s_reg.dly;
                ADR_PSR:  s_next.rdata = s_reg.psr;
                default: begin
                    s_next.rdata = RST_ZERO;
                    s_next.rresp = RESP_SLVERR;
                end
            endcase
        end else if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg      <= '0;
            s_reg.ctrl <= RST_CTRL;
            s_reg.cfg  <= RST_ZERO;
            s_reg.minp <= RST_ZERO;
            s_reg.dly  <= RST_ZERO;
            s_reg.psr  <= RST_ZERO;
        end else begin
            s_reg <= s_next;
        end
    end

    // Bus outputs
    assign s_axi_awready = !s_reg.aw_hold;
    assign s_axi_wready  = !s_reg.w_hold;
    assign s_axi_bvalid  = s_reg.bvalid;
    assign s_axi_bresp   = s_reg.bresp;
    assign s_axi_arready = !s_reg.rvalid;
    assign s_axi_rvalid  = s_reg.rvalid;
    assign s_axi_rresp   = s_reg.rresp;
    assign s_axi_rdata   = {24'h000000, s_reg.rdata};

    // Supply rejection pins follow their stored bits
    assign supply_reject_enable  = s_reg.psr[SUPPLY_REJECT_ENABLE];
    assign supply_reject_reset_n = s_reg.psr[PSR_RST];
    assign feedback_enable       = s_reg.psr[PSR_FB];

    supply_sync_gen u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .div_code (s_reg.psr[PSR_DIV_LSB +: 3]),
        .sync_clk (supply_sync_clock)
    );

    // One shaper per channel; B channels carry no pair delay
    generate
        for (genvar i = 0; i < NCH; i++) begin : g_chan
            logic [1:0] leg;
            pwm_leg_shaper u_shaper (
                .aclk          (aclk),
                .aresetn       (aresetn),
                .mclk_en       (mclk_en),
                .min_pulse     (s_reg.minp[MINP_LSB +: 5]),
                .leg_delay     (s_reg.dly[DLY_LEG_LSB +: 3]),
                .pair_delay    ((i % 2 == 0) ? s_reg.dly[DLY_PR_LSB +: 5] : 5'h00),
                .full_bridge   (full_bridge[i]),
                .minus_disable (s_reg.minp[MINP_DIS]),
                .raw           ({mod_minus[i], mod_plus[i]}),
                .leg_out       (leg)
            );
            assign pwm_plus_out[i]  = leg[0];
            assign pwm_minus_out[i] = leg[1];
        end
    endgenerate

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence cfg_write_ok;
        wr_fire && s_reg.aw_addr == ADR_CFG && s_reg.w_lane && power_down_bit;
    endsequence

    sequence psr_write_ok;
        wr_fire && s_reg.aw_addr == ADR_PSR && s_reg.w_lane;
    endsequence

    a_cfg_locked: assert property (
        (wr_fire && s_reg.aw_addr != ADR_CTRL && s_reg.aw_addr != ADR_PSR && !power_down_bit)
        |=> $stable({s_reg.cfg, s_reg.minp, s_reg.dly}))
        else $error("setting changed while running");

    a_pair2_mode: assert property (
        cfg_write_ok |=> (full_bridge[3:2] == {2{$past(s_reg.w_data[CFG_P2])}}))
        else $error("pair two mode wrong");

    a_a3_mode: assert property (
        cfg_write_ok |=> (full_bridge[4] == $past(s_reg.w_data[CFG_A3])))
        else $error("channel A3 mode wrong");

    a_b3_mode: assert property (
        cfg_write_ok |=> (full_bridge[5] == $past(s_reg.w_data[CFG_B3])))
        else $error("channel B3 mode wrong");

    a_pair4_mode: assert property (
        cfg_write_ok |=> (full_bridge[7:6] == {2{$past(s_reg.w_data[CFG_P4])}}))
        else $error("pair four mode wrong");

    a_leg_reset: assert property (disable iff (1'b0)
        !aresetn |=> s_reg.dly[DLY_LEG_LSB +: 3] == 3'h0)
        else $error("leg delay not zero after reset");

    a_bridge_reset: assert property (disable iff (1'b0)
        !aresetn |=> (full_bridge == '0 && !s_reg.minp[MINP_DIS]))
        else $error("bridge bits not cleared by reset");

    a_psr_enable: assert property (
        psr_write_ok |=> supply_reject_enable == $past(s_reg.w_data[SUPPLY_REJECT_ENABLE]))
        else $error("supply rejection enable level wrong");

    // Only a write to the supply register may release the reset
    a_supply_reject_reset: assert property (
        (!supply_reject_reset_n && !(wr_fire && s_reg.aw_addr == ADR_PSR))
        |=> !supply_reject_reset_n)
        else $error("supply rejection reset released early");

    a_write_answer: assert property (
        wr_fire |=> s_axi_bvalid && !s_axi_awready == 1'b0)
        else $error("write not answered");
endmodule

// ==== test/power_stage_model.sv ====
// Far-side power stage: notes which legs it has seen driven high.
// Assumes legs are registered levels on aclk; clear is a bench strobe.
`timescale 1ns/100ps
module power_stage_model
    import pwm_stage_pkg::*;
(
    // Clock and clear
    input  wire logic           aclk,
    input  wire logic           clear,
    // Bridge legs from the block
    input  wire logic [NCH-1:0] leg_plus,
    input  wire logic [NCH-1:0] leg_minus,
    // Legs seen high since the last clear
    output logic [NCH-1:0]      plus_seen,
    output logic [NCH-1:0]      minus_seen
);
    // Sticky, so one short glitch on a muted leg still shows
    always_ff @(posedge aclk) begin
        if (clear) begin
            plus_seen  <= '0;
            minus_seen <= '0;
        end else begin
            plus_seen  <= plus_seen | leg_plus;
            minus_seen <= minus_seen | leg_minus;
        end
    end
endmodule

// ==== test/pwm_output_stage_config_tb.sv ====
// Self-checking bench for the output stage configuration block.
// Assumes mclk_en ticks every fourth aclk; the bench makes it.
`timescale 1ns/100ps
module pwm_output_stage_config_tb;
    import pwm_stage_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, mclk_en, clear;
    logic sre, srr_n, fbe, sync;
    logic [7:0]  awaddr, araddr, mod_plus, mod_minus, pout, mout, pp, pm, ps, ms;
    logic [31:0] wdata, rdata, rv;
    logic [1:0]  bresp, rresp, tdiv;
    logic [33:0] exp_q[$];
    int num_errors, compares, seed, tick_cnt, t_pb, t_mb, t_pa, t_fb, st[4];

    pwm_output_stage_config u_pwm_output_stage_config (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .mclk_en(mclk_en), .mod_plus(mod_plus),
        .mod_minus(mod_minus), .pwm_plus_out(pout), .pwm_minus_out(mout),
        .supply_reject_enable(sre), .supply_reject_reset_n(srr_n),
        .feedback_enable(fbe), .supply_sync_clock(sync));
    power_stage_model u_power_stage_model (.aclk(aclk), .clear(clear),
        .leg_plus(pout), .leg_minus(mout), .plus_seen(ps), .minus_seen(ms));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic close_out;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [33:0] e, input logic [33:0] g);
        compares++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", what, e, g);
            num_errors++;
        end
    endtask

    task automatic stall;
        num_errors++;
        close_out();
    endtask

    // Bus answers are judged by the watcher against queued notes
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        int n;
        exp_q.push_back({r, 32'h0});
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100 && !(bvalid && bready); n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        if (n == 100) stall();
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        int n;
        exp_q.push_back({r, 24'h0, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100 && !(rvalid && rready); n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end
        if (n == 100) stall();
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic ticks(input int n);
        repeat (4 * n) @(posedge aclk);
    endtask

    always @(posedge aclk) begin
        if (bvalid && bready) chk("bresp", exp_q.pop_front(), {bresp, 32'h0});
        if (rvalid && rready) chk("read", exp_q.pop_front(), {rresp, rdata});
    end

    // Master clock ticks and edge stamps counted in ticks
    always @(posedge aclk) begin
        if (!aresetn) begin
            tdiv <= 2'h0;
            mclk_en <= 1'b0;
            tick_cnt <= 0;
        end else begin
            tdiv <= tdiv + 2'h1;
            mclk_en <= (tdiv == 2'h3);
            if (mclk_en) tick_cnt <= tick_cnt + 1;
        end
        pp <= pout;
        pm <= mout;
        if (pout[1] && !pp[1]) t_pb <= tick_cnt;
        if (mout[1] && !pm[1]) t_mb <= tick_cnt;
        if (pout[0] && !pp[0]) t_pa <= tick_cnt;
        if (!pout[1] && pp[1]) t_fb <= tick_cnt;
    end

    initial begin
        logic [7:0] cfgm[5] = '{8'hC0, 8'h20, 8'h10, 8'h0C, 8'h03};
        int rows[7][5] = '{'{0, 'h60, 4, 0, 3}, '{0, 'hE0, 4, 0, 7}, '{0, 'h05, 4, 1, 5},
            '{0, 'h1F, 4, 1, 31}, '{6, 0, 1, 2, 6}, '{31, 0, 1, 2, 31}, '{0, 0, 2, 2, 2}};
        int i, k, n, t0;
        logic prev;
        seed = 58;
        {awvalid, wvalid, bready, arvalid, rready, clear} = '0;
        {awaddr, araddr, wdata, mod_plus, mod_minus} = '0;
        {num_errors, compares} = '0;
        aresetn = 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(ADR_CTRL, 8'h01, RESP_OKAY);
        rd(ADR_CFG, 8'h00, RESP_OKAY);
        rd(ADR_MINP, 8'h00, RESP_OKAY);
        rd(ADR_DLY, 8'h00, RESP_OKAY);
        rd(ADR_PSR, 8'h00, RESP_OKAY);
        rd(8'hFC, 8'h00, RESP_SLVERR);
        wr(8'hFC, 8'h55, RESP_SLVERR);
        $display("done: reset values");
        for (i = 0; i < 4; i++) begin
            rv = $random(seed);
            wr(ADR_CTRL, 8'h01, RESP_OKAY);
            wr(ADR_CFG, rv[7:0], RESP_OKAY);
            wr(ADR_MINP, rv[15:8], RESP_OKAY);
            wr(ADR_DLY, rv[23:16], RESP_OKAY);
            wr(ADR_CTRL, 8'h00, RESP_OKAY);
            wr(ADR_CFG, ~rv[7:0], RESP_OKAY);
            wr(ADR_MINP, ~rv[15:8], RESP_OKAY);
            wr(ADR_DLY, ~rv[23:16], RESP_OKAY);
            rd(ADR_CFG, rv[7:0] & MASK_CFG, RESP_OKAY);
            rd(ADR_MINP, rv[15:8] & MASK_MINP, RESP_OKAY);
            rd(ADR_DLY, rv[23:16] & MASK_DLY, RESP_OKAY);
        end
        wr(ADR_PSR, 8'hE0, RESP_OKAY);
        chk("psr enable", 1, sre);
        chk("supply_reject_reset_n", 1, srr_n);
        chk("psr feedback", 1, fbe);
        wr(ADR_PSR, 8'h00, RESP_OKAY);
        chk("psr enable", 0, sre);
        chk("supply_reject_reset_n", 0, srr_n);
        chk("psr feedback", 0, fbe);
        $display("done: power-down lock and supply bits");
        wr(ADR_CTRL, 8'h01, RESP_OKAY);
        wr(ADR_DLY, 8'h00, RESP_OKAY);
        mod_plus <= 8'hFF;
        mod_minus <= 8'hFF;
        for (i = 0; i < 6; i++) begin
            wr(ADR_MINP, (i < 5) ? 8'h80 : 8'h00, RESP_OKAY);
            wr(ADR_CFG, (i < 5) ? 8'(1 << i) : 8'h00, RESP_OKAY);
            ticks(10);
            clear <= 1'b1;
            @(posedge aclk);
            clear <= 1'b0;
            ticks(10);
            chk("minus legs", (i < 5) ? cfgm[i] : 8'hFF, ms);
            chk("plus legs", 8'hFF, ps);
        end
        $display("done: bridge modes");
        for (i = 0; i < 7; i++) begin
            mod_plus <= 8'h00;
            mod_minus <= 8'h00;
            wr(ADR_MINP, 8'(rows[i][0]), RESP_OKAY);
            wr(ADR_DLY, 8'(rows[i][1]), RESP_OKAY);
            ticks(80);
            mod_plus <= 8'hFF;
            mod_minus <= 8'hFF;
            ticks(rows[i][2]);
            mod_plus <= 8'h00;
            mod_minus <= 8'h00;
            ticks(80);
            st = '{t_mb - t_pb, t_pa - t_pb, t_fb - t_pb, 0};
            chk("tick count", rows[i][4], st[rows[i][3]]);
        end
        $display("done: delays and minimum pulse");
        for (k = 0; k < 8; k++) begin
            wr(ADR_PSR, 8'(k), RESP_OKAY);
            t0 = -1;
            // Start high so a clock already running is not a false edge
            prev = 1'b1;
            for (n = 0; n < 2600; n++) begin
                @(posedge aclk);
                if (sync && !prev) begin
                    if (t0 >= 0) break;
                    t0 = n;
                end
                prev = sync;
            end
            chk("sync period", (k == 0 || k == 7) ? 0 : 32 << (k - 1), (t0 < 0) ? 0 : n - t0);
        end
        $display("done: sync divider");
        close_out();
    end
endmodule
